// ===== core/usm_spi_master.sv
`timescale 1ns/10ps
module usm_spi_master
  import usm_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        core_global_irq_en_i,
  input  wire logic        txc_irq_ack_i,
  output logic             rx_irq_o,
  output logic             tx_irq_o,
  output logic             dre_irq_o,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  input  wire logic        serial_in_pin_i,
  output logic             serial_in_pin_owned_o
);

  function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
    return idx == want;
  endfunction

  function automatic logic out_bit(input logic [7:0] d, input logic lsb);
    return lsb ? d[0] : d[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb);
    return lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
    return lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  // Bus side
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [7:0]  ctrl_b_q;
  logic [7:0]  ctrl_c_q;
  logic [11:0] div_q;
  logic        txc_q;
  logic [7:0]  tx_buf_q;
  logic        tx_full_q;
  // Link side
  logic        in_s1_q;
  logic        in_s2_q;
  usm_state_e  state_q;
  usm_state_e  state_d;
  logic [7:0]  tx_sh_q;
  logic [7:0]  rx_sh_q;
  logic [2:0]  bit_cnt_q;
  logic        sck_q;
  logic        sck_d;
  logic        mosi_q;
  logic [4:0]  edge_cnt_q;

  wire  [9:0]  idx_w     = wb_adr_i[11:2];
  wire         req_w     = wb_cyc_i & wb_stb_i;
  wire         wr_w      = req_w & ack_q & wb_we_i & wb_sel_i[0];
  wire         rd_w      = req_w & ack_q & !wb_we_i;
  wire         stat_wr_w = wr_w & hit(idx_w, IDX_STATUS);
  wire         dat_wr_w  = wr_w & hit(idx_w, IDX_DATA);
  wire         dat_rd_w  = rd_w & hit(idx_w, IDX_DATA);

  wire         rxcie_w   = ctrl_b_q[B_RXCIE];
  wire         txcie_w   = ctrl_b_q[B_TXCIE];
  wire         dreie_w   = ctrl_b_q[B_DREIE];
  wire         rx_en_w   = ctrl_b_q[B_RXEN];
  wire         tx_en_w   = ctrl_b_q[B_TXEN];
  wire  [1:0]  mode_w    = {ctrl_c_q[B_MODE_HI], ctrl_c_q[B_MODE_LO]};
  wire         spi_mode_w = (mode_w == MODE_SPI);
  wire         lsb_w     = ctrl_c_q[B_ORDER];
  wire         cpha_w    = ctrl_c_q[B_CPHA];
  wire         cpol_w    = ctrl_c_q[B_CPOL];

  logic        tick_w;
  logic        rxc_w;
  logic [7:0]  rx_head_w;

  wire         busy_w       = (state_q != ST_IDLE);
  wire         lead_edge_w  = (state_q == ST_LEAD) & tick_w;
  wire         trail_edge_w = (state_q == ST_TRAIL) & tick_w;
  wire         frame_end_w  = trail_edge_w & (bit_cnt_q == LAST_BIT);
  // Next byte follows at once when the buffer already holds it
  wire         load_w       = tx_full_q & spi_mode_w & (!busy_w | frame_end_w);
  wire         sample_w     = cpha_w ? trail_edge_w : lead_edge_w;
  wire         setup_w      = cpha_w ? lead_edge_w : (trail_edge_w & !frame_end_w);
  wire  [7:0]  rx_word_w    = cpha_w ? shift_in(rx_sh_q, in_s2_q, lsb_w) : rx_sh_q;

  wire         dre_w       = !tx_full_q;
  wire         dat_wr_ok_w = dat_wr_w & tx_en_w & !tx_full_q;
  wire         txc_set_w   = frame_end_w & !tx_full_q;
  wire         txc_clr_w   = txc_irq_ack_i | (stat_wr_w & wb_dat_i[B_TXC]);
  wire         tx_own_w    = tx_en_w | busy_w | tx_full_q;

  // Error flag positions stay zero in this mode
  wire  [7:0]  status_w = {rxc_w, txc_q, dre_w, 5'h00};
  wire  [7:0]  rd_mux_w =
    hit(idx_w, IDX_STATUS)  ? status_w :
    hit(idx_w, IDX_CTRL_B)  ? (ctrl_b_q & CTRL_B_MASK) :
    hit(idx_w, IDX_CTRL_C)  ? ctrl_c_q :
    hit(idx_w, IDX_BAUD_LO) ? div_q[7:0] :
    hit(idx_w, IDX_BAUD_HI) ? {4'h0, div_q[11:8]} :
    hit(idx_w, IDX_DATA)    ? rx_head_w : 8'h00;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  assign rx_irq_o  = rxcie_w & core_global_irq_en_i & rxc_w;
  assign tx_irq_o  = txcie_w & core_global_irq_en_i & txc_q;
  assign dre_irq_o = dreie_w & core_global_irq_en_i & dre_w;

  // Slave select is left to general-purpose pins
  assign serial_clock_pin_o    = sck_q;
  assign serial_clock_pin_oe_o = tx_own_w;
  assign serial_out_pin_o      = mosi_q;
  assign serial_out_pin_oe_o   = tx_own_w;
  assign serial_in_pin_owned_o = rx_en_w;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req_w & !ack_q;
      if (req_w && !ack_q)
        rdat_q <= {24'h00_0000, rd_mux_w};
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_b_q <= CTRL_B_RST;
      ctrl_c_q <= CTRL_C_RST;
      div_q    <= BAUD_RST;
    end
    else if (wr_w)
    begin
      if (hit(idx_w, IDX_CTRL_B))
        ctrl_b_q <= wb_dat_i[7:0] & CTRL_B_MASK;
      if (hit(idx_w, IDX_CTRL_C))
        ctrl_c_q <= wb_dat_i[7:0];
      if (hit(idx_w, IDX_BAUD_LO))
        div_q[7:0] <= wb_dat_i[7:0];
      if (hit(idx_w, IDX_BAUD_HI))
        div_q[11:8] <= wb_dat_i[3:0];
    end
  end

  // Set beats clear so a frame ending with the clear is still reported
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      txc_q <= STATUS_RST[B_TXC];
    else if (txc_set_w)
      txc_q <= 1'b1;
    else if (txc_clr_w)
      txc_q <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end
    else if (load_w)
      tx_full_q <= 1'b0;
    else if (dat_wr_ok_w)
    begin
      tx_full_q <= 1'b1;
      tx_buf_q  <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
    end
    else
    begin
      in_s1_q <= serial_in_pin_i;
      in_s2_q <= in_s1_q;
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (load_w) state_d = ST_LEAD;
      ST_LEAD:  if (tick_w) state_d = ST_TRAIL;
      ST_TRAIL: if (tick_w) state_d = (frame_end_w && !load_w) ? ST_IDLE : ST_LEAD;
      default:  state_d = ST_IDLE;
    endcase
  end

  // Clock is active only in the second half of each bit
  assign sck_d = cpol_w ^ (state_d == ST_TRAIL);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
      sck_q   <= CTRL_C_RST[B_CPOL];
    end
    else
    begin
      state_q <= state_d;
      sck_q   <= sck_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bit_cnt_q <= 3'h0;
    else if (load_w)
      bit_cnt_q <= 3'h0;
    else if (trail_edge_w)
      bit_cnt_q <= bit_cnt_q + 3'h1;
  end

  // With phase zero the first bit must be on the line before the first edge
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tx_sh_q <= 8'h00;
      mosi_q  <= MOSI_IDLE;
    end
    else if (load_w)
    begin
      tx_sh_q <= cpha_w ? tx_buf_q : shift_out(tx_buf_q, lsb_w);
      if (!cpha_w)
        mosi_q <= out_bit(tx_buf_q, lsb_w);
    end
    else if (setup_w)
    begin
      mosi_q  <= out_bit(tx_sh_q, lsb_w);
      tx_sh_q <= shift_out(tx_sh_q, lsb_w);
    end
    else if ((frame_end_w && !cpha_w) || !busy_w)
      mosi_q <= MOSI_IDLE;
  end

  // Input sampling lags the pin by the two-stage synchroniser
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rx_sh_q <= 8'h00;
    else if (sample_w)
      rx_sh_q <= shift_in(rx_sh_q, in_s2_q, lsb_w);
  end

  usm_baud_gen u_baud (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (busy_w),
    .div_i      (div_q),
    .tick_o     (tick_w)
  );

  usm_rx_buf u_rx_buf (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .push_i     (frame_end_w & rx_en_w),
    .data_i     (rx_word_w),
    .pop_i      (dat_rd_w),
    .flush_i    (!rx_en_w),
    .data_o     (rx_head_w),
    .valid_o    (rxc_w)
  );

  // Helper for checking the clock edge count of a frame
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      edge_cnt_q <= 5'h00;
    else if (load_w)
      edge_cnt_q <= 5'h00;
    else if (busy_w && sck_d != sck_q)
      edge_cnt_q <= edge_cnt_q + 5'h01;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_status_read;
    req_w && !ack_q && !wb_we_i && hit(idx_w, IDX_STATUS);
  endsequence

  property p_status_read;
    s_status_read |=> (wb_ack_o && wb_dat_o[4:0] == 5'h00
                       && wb_dat_o[B_DRE] == $past(!tx_full_q));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_rx_flush;
    !rx_en_w |=> !rxc_w;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("disabled receiver kept data");

  property p_txc_set;
    (frame_end_w && !tx_full_q) |=> (txc_q && state_q == ST_IDLE);
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("transmit done not set");

  property p_txc_clr;
    (txc_irq_ack_i && !frame_end_w) |=> !txc_q;
  endproperty
  a_txc_clr: assert property (p_txc_clr) else $error("transmit done not cleared");

  property p_irq_gate;
    !core_global_irq_en_i |-> !(rx_irq_o || tx_irq_o || dre_irq_o);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");

  sequence s_start;
    (state_q == ST_IDLE) && tx_full_q && spi_mode_w;
  endsequence

  property p_start;
    s_start |=> (state_q == ST_LEAD && !tx_full_q && dre_w) ##1 busy_w;
  endproperty
  a_start: assert property (p_start) else $error("write did not start frame");

  property p_frame_edges;
    frame_end_w |-> (edge_cnt_q == FRAME_EDGES_PRE);
  endproperty
  a_frame_edges: assert property (p_frame_edges) else $error("frame edge count wrong");

  property p_idle_clock;
    (state_q == ST_IDLE && $stable(cpol_w))[*2] |-> (sck_q == cpol_w && mosi_q == MOSI_IDLE);
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("idle clock level wrong");

  property p_tx_hold;
    ($fell(tx_en_w) && busy_w) |-> serial_out_pin_oe_o;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("pin released mid frame");

endmodule // usm_spi_master

// ===== core/usm_pkg.sv
package usm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_STATUS  = 10'h0C0;
  localparam logic [9:0]  IDX_CTRL_B  = 10'h0C1;
  localparam logic [9:0]  IDX_CTRL_C  = 10'h0C2;
  localparam logic [9:0]  IDX_BAUD_LO = 10'h0C4;
  localparam logic [9:0]  IDX_BAUD_HI = 10'h0C5;
  localparam logic [9:0]  IDX_DATA    = 10'h0C6;

  localparam logic [7:0]  STATUS_RST  = 8'h20;
  localparam logic [7:0]  CTRL_B_RST  = 8'h00;
  localparam logic [7:0]  CTRL_C_RST  = 8'h06;
  localparam logic [7:0]  CTRL_B_MASK = 8'hF8;
  localparam logic [11:0] BAUD_RST    = 12'h000;
  localparam logic        MOSI_IDLE   = 1'b1;

  // Status bits
  localparam int B_RXC   = 7;
  localparam int B_TXC   = 6;
  localparam int B_DRE   = 5;
  // Interrupt and enable control bits
  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_DREIE = 5;
  localparam int B_RXEN  = 4;
  localparam int B_TXEN  = 3;
  // Mode and format bits
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_ORDER   = 2;
  localparam int B_CPHA    = 1;
  localparam int B_CPOL    = 0;

  localparam logic [1:0] MODE_ASYNC = 2'b00;
  localparam logic [1:0] MODE_SYNC  = 2'b01;
  localparam logic [1:0] MODE_RSVD  = 2'b10;
  localparam logic [1:0] MODE_SPI   = 2'b11;

  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam logic [4:0] FRAME_EDGES_PRE = 5'h0F;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } usm_state_e;

endpackage

// ===== core/usm_baud_gen.sv
`timescale 1ns/10ps
module usm_baud_gen
  import usm_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        run_i,
  input  wire logic [11:0] div_i,
  output logic             tick_o
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Half bit period is div plus one clocks; stopped counter holds the reload
  assign tick_o = run_i & (cnt_q == 12'h000);
  assign cnt_d  = (!run_i || tick_o) ? div_i : cnt_q - 12'h001;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_q <= BAUD_RST;
    else
      cnt_q <= cnt_d;
  end

  property p_first_tick;
    (!run_i && div_i == 12'h003) ##1 (run_i && div_i == 12'h003)[*4] |-> tick_o;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("baud tick late");

endmodule // usm_baud_gen

// ===== core/usm_rx_buf.sv
`timescale 1ns/10ps
module usm_rx_buf
  import usm_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       push_i,
  input  wire logic [7:0] data_i,
  input  wire logic       pop_i,
  input  wire logic       flush_i,
  output logic [7:0]      data_o,
  output logic            valid_o
);

  logic [7:0] head_q;
  logic [7:0] tail_q;
  logic [1:0] cnt_q;
  logic       pop_ok_w;
  logic       push_ok_w;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Two levels; a full buffer drops the newest byte and keeps older ones
  assign pop_ok_w  = pop_i & (cnt_q != 2'h0);
  assign push_ok_w = push_i & ((cnt_q != 2'h2) | pop_ok_w);
  assign data_o    = head_q;
  assign valid_o   = (cnt_q != 2'h0);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_q <= 2'h0;
    else if (flush_i)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + {1'b0, push_ok_w} - {1'b0, pop_ok_w};
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      head_q <= 8'h00;
      tail_q <= 8'h00;
    end
    else
    begin
      if (push_ok_w && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop_ok_w)))
        head_q <= data_i;
      else if (pop_ok_w && cnt_q == 2'h2)
        head_q <= tail_q;
      if (push_ok_w && ((cnt_q == 2'h1 && !pop_ok_w) || cnt_q == 2'h2))
        tail_q <= data_i;
    end
  end

  property p_push_shows;
    (push_i && cnt_q == 2'h0 && !flush_i) |=> (valid_o && data_o == $past(data_i));
  endproperty
  a_push_shows: assert property (p_push_shows) else $error("pushed byte not shown");

  property p_full_keeps;
    (push_i && !pop_i && !flush_i && cnt_q == 2'h2) |=> (cnt_q == 2'h2 && $stable(head_q));
  endproperty
  a_full_keeps: assert property (p_full_keeps) else $error("full buffer lost old byte");

endmodule // usm_rx_buf

// ===== testbench/usm_spi_slave_model.sv
`timescale 1ns/10ps
module usm_spi_slave_model
(
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o,
  output int              frames_o
);
  logic [7:0] cur;
  logic [7:0] sh;
  int         tix;
  int         rix;

  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb_i ? b[i] : b[7-i];
  endfunction

  initial
  begin
    miso_o = 1'b0;
    got_o = 8'h00;
    frames_o = 0;
  end

  // Selected by software through a plain line, never by the master
  always @(negedge sel_n_i)
  begin
    cur = reply_i + frames_o[7:0];
    tix = 0;
    rix = 0;
    if (!cpha_i)
    begin
      miso_o = pick(cur, 0);
      tix = 1;
    end
  end

  // Released line must not keep its last level
  always @(posedge sel_n_i)
    miso_o = ~miso_o;

  always @(sck_i)
    if (sel_n_i === 1'b0)
    begin
      if ((sck_i != cpol_i) ^ cpha_i)
      begin
        sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
        rix++;
        if (rix == 8)
        begin
          got_o = sh;
          frames_o++;
          rix = 0;
        end
      end
      else
      begin
        if (tix == 8)
        begin
          cur = reply_i + frames_o[7:0];
          tix = 0;
        end
        miso_o = pick(cur, tix);
        tix++;
      end
    end
endmodule // usm_spi_slave_model

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench
  import usm_pkg::*;
;
  logic        clk, rst, cyc, stb, we, gie, tack, sel_n, cpol, cpha, lsb;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  reply, got, rd;
  logic        ack, rxi, txi, drei, sck, sck_oe, mosi, mosi_oe, mosi_w, miso, owned;
  int          frames, num_errors, samples_checked, cycles, edges, half_ns;
  realtime     t_last;

  assign mosi_w = mosi_oe ? mosi : 1'b1;

  usm_spi_master i_usm_spi_master (
    .core_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .core_global_irq_en_i(gie), .txc_irq_ack_i(tack), .rx_irq_o(rxi), .tx_irq_o(txi),
    .dre_irq_o(drei), .serial_clock_pin_o(sck), .serial_clock_pin_oe_o(sck_oe),
    .serial_out_pin_o(mosi), .serial_out_pin_oe_o(mosi_oe), .serial_in_pin_i(miso),
    .serial_in_pin_owned_o(owned));

  usm_spi_slave_model i_usm_spi_slave_model (
    .sck_i(sck), .mosi_i(mosi_w), .sel_n_i(sel_n), .cpol_i(cpol), .cpha_i(cpha),
    .lsb_i(lsb), .reply_i(reply), .miso_o(miso), .got_o(got), .frames_o(frames));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(sck)
  begin
    edges++;
    half_ns = int'($realtime - t_last);
    t_last = $realtime;
  end

  function automatic logic [7:0] w8(input logic x);
    return {7'h00, x};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; the slave's latency is not assumed
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // One more edge so the effects of this access have settled before anyone looks
    @(posedge clk);
    chk("ack drop", 8'h00, w8(ack));
  endtask

  task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
    bus(idx, 1'b0, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(IDX_STATUS, 1'b0, 8'h00);
      n++;
    end
    while (rd[b] !== v && n < 200);
    chk("status wait", w8(v), w8(rd[b]));
  endtask

  // Slave is deselected first so a polarity change is no clock edge to it
  task automatic cfg(input logic [2:0] f);
    sel_n <= 1'b1;
    bus(IDX_CTRL_C, 1'b1, {5'b11000, f});
    lsb <= f[2];
    cpha <= f[1];
    cpol <= f[0];
    @(posedge clk);
  endtask

  task automatic t_reset();
    rchk("status", IDX_STATUS, 8'h20);
    rchk("ctrl_b", IDX_CTRL_B, 8'h00);
    rchk("ctrl_c", IDX_CTRL_C, 8'h06);
    rchk("unmapped", 10'h0C3, 8'h00);
    chk("out idle", 8'h01, w8(mosi));
    chk("out oe", 8'h00, w8(mosi_oe));
    chk("clock oe", 8'h00, w8(sck_oe));
    chk("in owned", 8'h00, w8(owned));
    $display("test reset done");
  endtask

  task automatic t_mode_sel();
    bus(IDX_CTRL_B, 1'b1, 8'h08);
    bus(IDX_BAUD_LO, 1'b1, 8'h03);
    chk("out oe", 8'h01, w8(mosi_oe));
    bus(IDX_DATA, 1'b1, 8'h3C);
    for (int i = 0; i < 3; i++)
    begin
      bus(IDX_CTRL_C, 1'b1, {i[1:0], 6'h00});
      edges = 0;
      repeat (100) @(posedge clk);
      chk("no clock", 8'h00, 8'(edges));
    end
    bus(IDX_CTRL_C, 1'b1, 8'hC0);
    wait_st(B_TXC, 1'b1);
    rchk("status", IDX_STATUS, 8'h60);
    $display("test mode select done");
  endtask

  task automatic t_irq();
    bus(IDX_CTRL_B, 1'b1, 8'hE8);
    chk("tx irq gie0", 8'h00, w8(txi));
    chk("dre irq gie0", 8'h00, w8(drei));
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    chk("tx irq", 8'h01, w8(txi));
    chk("dre irq", 8'h01, w8(drei));
    chk("rx irq", 8'h00, w8(rxi));
    tack <= 1'b1;
    @(posedge clk);
    tack <= 1'b0;
    rchk("status", IDX_STATUS, 8'h20);
    chk("tx irq off", 8'h00, w8(txi));
    $display("test irq done");
  endtask

  task automatic t_modes();
    logic [7:0] d;
    logic [7:0] e;
    bus(IDX_CTRL_B, 1'b1, 8'h98);
    chk("in owned", 8'h01, w8(owned));
    for (int k = 0; k < 8; k++)
    begin
      cfg(k[2:0]);
      d = 8'h1D + 8'(k * 34);
      e = reply + frames[7:0];
      sel_n <= 1'b0;
      bus(IDX_DATA, 1'b1, d);
      wait_st(B_RXC, 1'b1);
      chk("rx irq", 8'h01, w8(rxi));
      rchk("rx data", IDX_DATA, e);
      chk("slave got", d, got);
      chk("clock idle", w8(k[0]), w8(sck));
      chk("half bit", 8'h04, 8'(half_ns / 100));
      bus(IDX_STATUS, 1'b1, 8'h40);
      rchk("status", IDX_STATUS, 8'h20);
    end
    $display("test modes done");
  endtask

  task automatic t_b2b();
    logic [7:0] e;
    int f0;
    cfg(3'b000);
    e = reply + frames[7:0];
    f0 = frames;
    sel_n <= 1'b0;
    bus(IDX_DATA, 1'b1, 8'hA1);
    wait_st(B_DRE, 1'b1);
    bus(IDX_DATA, 1'b1, 8'hB2);
    rchk("buffer full", IDX_STATUS, 8'h00);
    wait_st(B_DRE, 1'b1);
    bus(IDX_DATA, 1'b1, 8'hC3);
    wait_st(B_TXC, 1'b1);
    rchk("first", IDX_DATA, e);
    rchk("second", IDX_DATA, e + 8'h01);
    rchk("status", IDX_STATUS, 8'h60);
    chk("slave got", 8'hC3, got);
    chk("frames", 8'h03, 8'(frames - f0));
    bus(IDX_STATUS, 1'b1, 8'h40);
    $display("test back to back done");
  endtask

  task automatic t_rx_dis();
    bus(IDX_DATA, 1'b1, 8'h77);
    wait_st(B_RXC, 1'b1);
    wait_st(B_TXC, 1'b1);
    bus(IDX_CTRL_B, 1'b1, 8'h08);
    rchk("status", IDX_STATUS, 8'h60);
    chk("in owned", 8'h00, w8(owned));
    $display("test rx disable done");
  endtask

  task automatic t_tx_dis();
    int n;
    n = 0;
    bus(IDX_STATUS, 1'b1, 8'h40);
    bus(IDX_DATA, 1'b1, 8'h99);
    bus(IDX_CTRL_B, 1'b1, 8'h00);
    chk("out oe held", 8'h01, w8(mosi_oe));
    while (mosi_oe === 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    rchk("status", IDX_STATUS, 8'h60);
    chk("out oe", 8'h00, w8(mosi_oe));
    chk("clock oe", 8'h00, w8(sck_oe));
    chk("slave got", 8'h99, got);
    $display("test tx disable done");
  endtask

  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, gie, tack, cpol, cpha, lsb} = 8'h00;
    sel_n = 1'b1;
    adr = 12'h000;
    wdat = 32'h00000000;
    reply = 8'h5A;
    {num_errors, samples_checked, cycles, edges, half_ns} = '0;
    t_last = 0.0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode_sel();
    t_irq();
    t_modes();
    t_b2b();
    t_rx_dis();
    t_tx_dis();
    summarize();
  end
endmodule // testbench
